// [origin_search_pkg.sv]
// constants and types shared by the origin search sequencer
package origin_search_pkg;

	// ************************************************************
	// widths and reset values
	// ************************************************************
	localparam int POS_W = 32;
	localparam int FEED_W = 16;
	localparam logic [31:0] POS_RESET = 32'h0000_0000;
	localparam logic [15:0] FEED_RESET = 16'h0000;
	// counter-pulse stop: cycles the speed command is held at zero after the direction is reversed
	localparam int STOP_NS = 1000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int STOP_CYCLES = (STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] STOP_CYCLES_V = 8'(STOP_CYCLES);
	// index-pulse watchdog after the sensor is passed, in cycles (parameter default)
	localparam int Z_TIMEOUT_CYCLES = 40000;

	// ************************************************************
	// configuration encodings
	// ************************************************************
	typedef enum logic [1:0] {
		METHOD_POWER_ON,
		METHOD_REVERSE,
		METHOD_ONE_DIR,
		METHOD_SPARE
	} method_t;

	// register-port offsets
	localparam logic [3:0] REG_CONFIG = 4'h0;
	localparam logic [3:0] REG_HIGH_FEED = 4'h1;
	localparam logic [3:0] REG_LOW_FEED = 4'h2;
	localparam logic [3:0] REG_OFFSET = 4'h3;
	localparam logic [3:0] REG_CONTROL = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h5;
	localparam logic [3:0] REG_ORIGIN = 4'h6;
	localparam logic [3:0] REG_POSITION = 4'h7;

	// config register fields
	localparam int CFG_METHOD_LSB = 0;
	localparam int CFG_DIR_BIT = 2;
	localparam int CFG_DECEL_BIT = 3;
	localparam int CFG_PROX_NC_BIT = 4;
	localparam int CFG_NO_PROX_BIT = 5;
	localparam int CFG_ABS_BIT = 6;
	localparam logic [6:0] CFG_RESET = 7'h01;

endpackage

// [sync2.sv]
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
module sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta;

	// first stage feeds only the second
	always_ff @(posedge clk) begin
		if (rst) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end

endmodule

// [origin_search_sequencer.sv]
// origin search sequencer for one servo axis
`timescale 1ns/10ps
module origin_search_sequencer
	import origin_search_pkg::*;
#(
	parameter int Z_TIMEOUT = Z_TIMEOUT_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	input wire logic cw_limit_n,
	input wire logic ccw_limit_n,
	input wire logic near_origin,
	input wire logic index_pulse,
	input wire logic abs_data_valid,
	input wire logic [origin_search_pkg::POS_W-1:0] abs_position,
	input wire logic [origin_search_pkg::POS_W-1:0] encoder_position,
	input wire logic ptp_done,
	output logic [origin_search_pkg::FEED_W-1:0] speed_cmd,
	output logic dir_cw,
	output logic run_cmd,
	output logic point_to_point_move,
	output logic [origin_search_pkg::POS_W-1:0] ptp_target,
	output logic abs_data_request,
	output logic busy,
	output logic search_error
);
	import origin_search_pkg::*;

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [3:0] pins_s;
	sync2 #(.W(4)) pin_sync (
		.clk(clk),
		.rst(rst),
		.d({cw_limit_n, ccw_limit_n, near_origin, index_pulse}),
		.q(pins_s)
	);

	logic cw_lim;
	logic ccw_lim;
	logic prox_raw;
	logic index_s;
	logic index_d;
	logic index_rise;
	logic prox;
	// open circuit on a limit input reads as limit reached
	assign cw_lim = ~pins_s[3];
	assign ccw_lim = ~pins_s[2];
	assign prox_raw = pins_s[1];
	assign index_s = pins_s[0];

	// ************************************************************
	// configuration registers
	// ************************************************************
	logic [6:0] cfg;
	logic [FEED_W-1:0] high_feed;
	logic [FEED_W-1:0] low_feed;
	logic [POS_W-1:0] ref_offset;
	logic run_on;
	logic [6:0] next_cfg;
	logic [FEED_W-1:0] next_high_feed;
	logic [FEED_W-1:0] next_low_feed;
	logic [POS_W-1:0] next_ref_offset;
	logic next_run_on;
	logic start_pulse;
	method_t method;
	logic init_dir_cw;
	logic decel_sel;
	logic prox_nc;
	logic no_prox;
	logic abs_axis;

	// seven parameters plus fitting options
	assign method = method_t'(cfg[CFG_METHOD_LSB +: 2]);
	assign init_dir_cw = cfg[CFG_DIR_BIT];
	assign decel_sel = cfg[CFG_DECEL_BIT];
	assign prox_nc = cfg[CFG_PROX_NC_BIT];
	assign no_prox = cfg[CFG_NO_PROX_BIT];
	assign abs_axis = cfg[CFG_ABS_BIT];
	// polarity chosen by software, nc wiring inverts
	assign prox = prox_nc ? ~prox_raw : prox_raw;
	// level alone never counts, only the rising edge
	assign index_rise = index_s & ~index_d;

	// register writes; control bit 0 starts, bit 1 is run command
	always_comb begin
		next_cfg = cfg;
		next_high_feed = high_feed;
		next_low_feed = low_feed;
		next_ref_offset = ref_offset;
		next_run_on = run_on;
		start_pulse = 1'b0;
		if (reg_write) begin
			if (reg_addr == REG_CONFIG) begin
				next_cfg = reg_wdata[6:0];
			end else if (reg_addr == REG_HIGH_FEED) begin
				next_high_feed = reg_wdata[FEED_W-1:0];
			end else if (reg_addr == REG_LOW_FEED) begin
				next_low_feed = reg_wdata[FEED_W-1:0];
			end else if (reg_addr == REG_OFFSET) begin
				next_ref_offset = reg_wdata;
			end else if (reg_addr == REG_CONTROL) begin
				start_pulse = reg_wdata[0];
				next_run_on = reg_wdata[1];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cfg <= CFG_RESET;
			high_feed <= FEED_RESET;
			low_feed <= FEED_RESET;
			ref_offset <= POS_RESET;
			run_on <= 1'b0;
			index_d <= 1'b0;
		end else begin
			cfg <= next_cfg;
			high_feed <= next_high_feed;
			low_feed <= next_low_feed;
			ref_offset <= next_ref_offset;
			run_on <= next_run_on;
			index_d <= index_s;
		end
	end

	// ************************************************************
	// search state machine
	// ************************************************************
	typedef enum {
		ST_IDLE,
		ST_HIGH,
		ST_LOW,
		ST_WAIT_Z,
		ST_STOP,
		ST_PTP,
		ST_DONE
	} state_t;

	state_t state;
	state_t next_state;
	state_t after_stop;
	state_t next_after_stop;
	logic [7:0] stop_cnt;
	logic [7:0] next_stop_cnt;
	logic [31:0] z_cnt;
	logic [31:0] next_z_cnt;
	logic next_dir_cw;
	logic next_error;
	logic next_ptp;
	logic [POS_W-1:0] next_ptp_target;
	logic [POS_W-1:0] origin;
	logic [POS_W-1:0] next_origin;
	logic [FEED_W-1:0] next_speed;
	logic limit_hit;
	logic power_done;
	logic next_power_done;

	assign limit_hit = dir_cw ? cw_lim : ccw_lim;

	always_comb begin
		next_state = state;
		next_after_stop = after_stop;
		next_stop_cnt = stop_cnt;
		next_z_cnt = z_cnt;
		next_dir_cw = dir_cw;
		next_error = search_error;
		next_ptp = 1'b0;
		next_ptp_target = ptp_target;
		next_origin = origin;
		next_speed = speed_cmd;
		next_power_done = power_done;
		case (state)
			ST_IDLE: begin
				next_speed = FEED_RESET;
				if (!power_done) begin
					next_power_done = 1'b1;
					if (method == METHOD_POWER_ON && !abs_axis) begin
						next_origin = encoder_position; // no motion
					end
				end else if (abs_axis) begin
					// data only arrives after the request, so capture whenever it is valid
					if (abs_data_valid) begin
						next_origin = encoder_position - abs_position;
					end
				end else if (start_pulse && method != METHOD_POWER_ON) begin
					next_error = 1'b0;
					next_dir_cw = init_dir_cw;
					next_speed = high_feed;
					next_state = ST_HIGH;
				end
			end
			ST_HIGH: begin
				if (prox) begin
					next_speed = low_feed;
					next_state = ST_LOW;
				end else if (limit_hit) begin
					if (method == METHOD_ONE_DIR && !no_prox) begin
						next_error = 1'b1;
						next_speed = FEED_RESET;
						next_state = ST_IDLE;
					end else if (no_prox) begin
						// limit stands in for the sensor
						next_speed = FEED_RESET;
						next_stop_cnt = STOP_CYCLES_V;
						next_dir_cw = ~dir_cw;
						next_after_stop = ST_LOW;
						next_state = ST_STOP;
					end else begin
						// counter-pulse stop, no ramp
						next_speed = FEED_RESET;
						next_stop_cnt = STOP_CYCLES_V;
						next_dir_cw = ~dir_cw;
						next_after_stop = ST_HIGH;
						next_state = ST_STOP;
					end
				end
			end
			ST_LOW: begin
				if (no_prox ? !limit_hit && !(cw_lim | ccw_lim) : !prox) begin
					next_z_cnt = 32'h0000_0000;
					next_state = ST_WAIT_Z; // sensor released
				end else if (limit_hit && !no_prox) begin
					next_speed = FEED_RESET;
					if (method == METHOD_ONE_DIR) begin
						next_error = 1'b1;
						next_state = ST_IDLE;
					end else begin
						next_stop_cnt = STOP_CYCLES_V;
						next_dir_cw = ~dir_cw;
						next_after_stop = ST_HIGH;
						next_state = ST_STOP;
					end
				end
			end
			ST_WAIT_Z: begin
				next_z_cnt = z_cnt + 32'h0000_0001;
				if (index_rise) begin
					next_origin = encoder_position;
					next_speed = FEED_RESET;
					next_ptp = 1'b1;
					next_ptp_target = encoder_position + ref_offset;
					next_state = ST_PTP;
				end else if (z_cnt >= 32'(Z_TIMEOUT) || limit_hit) begin
					next_error = 1'b1;
					next_speed = FEED_RESET;
					next_state = ST_IDLE;
				end
			end
			ST_STOP: begin
				next_speed = FEED_RESET;
				next_stop_cnt = stop_cnt - 8'h01;
				if (stop_cnt == 8'h01) begin
					next_speed = (after_stop == ST_HIGH) ? high_feed : low_feed;
					next_state = after_stop;
				end
			end
			ST_PTP: begin
				next_speed = FEED_RESET;
				if (ptp_done) begin
					next_origin = ptp_target; // reference origin
					next_state = ST_DONE;
				end
			end
			default: begin
				next_speed = FEED_RESET;
				next_state = ST_IDLE;
			end
		endcase
	end

	// decel method selects ramp elsewhere; reversals always abrupt here
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= ST_IDLE;
			after_stop <= ST_IDLE;
			stop_cnt <= 8'h00;
			z_cnt <= 32'h0000_0000;
			dir_cw <= 1'b1;
			search_error <= 1'b0;
			point_to_point_move <= 1'b0;
			ptp_target <= POS_RESET;
			origin <= POS_RESET;
			speed_cmd <= FEED_RESET;
			power_done <= 1'b0;
		end else begin
			state <= next_state;
			after_stop <= next_after_stop;
			stop_cnt <= next_stop_cnt;
			z_cnt <= next_z_cnt;
			dir_cw <= next_dir_cw;
			search_error <= next_error;
			point_to_point_move <= next_ptp;
			ptp_target <= next_ptp_target;
			origin <= next_origin;
			speed_cmd <= next_speed;
			power_done <= next_power_done;
		end
	end

	// busy from start until done or error
	assign busy = (state != ST_IDLE) && (state != ST_DONE);
	assign run_cmd = run_on;

	// ************************************************************
	// absolute data request
	// ************************************************************
	logic run_d;
	logic next_abs_req;
	// rises the cycle after the run command on an absolute axis so the encoder sends its data
	always_comb begin
		next_abs_req = abs_data_request;
		if (run_on && !run_d && abs_axis) begin
			next_abs_req = 1'b1;
		end else if (!run_on) begin
			next_abs_req = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			run_d <= 1'b0;
			abs_data_request <= 1'b0;
		end else begin
			run_d <= run_on;
			abs_data_request <= next_abs_req;
		end
	end

	// ************************************************************
	// register read port
	// ************************************************************
	logic [31:0] next_rdata;
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (reg_read) begin
			if (reg_addr == REG_CONFIG) begin
				next_rdata = {25'h0, cfg};
			end else if (reg_addr == REG_HIGH_FEED) begin
				next_rdata = {16'h0, high_feed};
			end else if (reg_addr == REG_LOW_FEED) begin
				next_rdata = {16'h0, low_feed};
			end else if (reg_addr == REG_OFFSET) begin
				next_rdata = ref_offset;
			end else if (reg_addr == REG_CONTROL) begin
				next_rdata = {30'h0, run_on, 1'b0};
			end else if (reg_addr == REG_STATUS) begin
				next_rdata = {28'h0, abs_data_request, dir_cw, search_error, busy};
			end else if (reg_addr == REG_ORIGIN) begin
				next_rdata = origin;
			end else if (reg_addr == REG_POSITION) begin
				next_rdata = encoder_position;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	start_high_speed_a: assert property (state == ST_IDLE && next_state == ST_HIGH |=> speed_cmd == high_feed && dir_cw == init_dir_cw) else $error("start not at high speed");
	prox_low_speed_a: assert property (state == ST_HIGH && prox && !decel_sel |=> speed_cmd == low_feed || decel_sel) else $error("no slow down at sensor");
	origin_zero_speed_a: assert property (state == ST_WAIT_Z && index_rise |=> speed_cmd == 16'h0000 && point_to_point_move) else $error("speed not zero at origin");
	reverse_flip_a: assert property (state == ST_HIGH && !prox && limit_hit && method == METHOD_REVERSE |=> state == ST_STOP && dir_cw != $past(dir_cw)) else $error("no reversal at limit");
	stop_no_ramp_a: assert property (state == ST_STOP |-> speed_cmd == 16'h0000) else $error("motion during stop");
	one_dir_error_a: assert property (state == ST_HIGH && !prox && limit_hit && method == METHOD_ONE_DIR && !no_prox |=> search_error && !busy) else $error("one direction limit not flagged");
	ptp_fix_a: assert property (state == ST_PTP && ptp_done |=> origin == $past(ptp_target) && !busy) else $error("reference origin not fixed");
	abs_req_rise_a: assert property ($rose(run_on) && abs_axis |=> abs_data_request) else $error("abs request missing");
	busy_hold_a: assert property (state == ST_HIGH |-> busy) else $error("busy dropped");
	z_edge_only_a: assert property (state == ST_WAIT_Z && index_s && index_d |=> state != ST_PTP) else $error("index level taken");

	search_ok_c: cover property (state == ST_PTP ##1 state == ST_DONE);
	reversal_c: cover property (state == ST_STOP ##1 state == ST_HIGH);
	error_c: cover property ($rose(search_error));
	abs_c: cover property ($rose(abs_data_request));

endmodule

// [axis_model.sv]
// behavioural axis: servodriver, encoder, limit and near-origin switches
`timescale 1ns/10ps
module axis_model
	import origin_search_pkg::*;
#(
	parameter int NEAR_LO = 20,
	parameter int NEAR_HI = 29,
	parameter int CW_END = 60,
	parameter int CCW_END = -10,
	parameter int STEP = 8,
	parameter logic [31:0] ABS_DATA = 32'h0000_0010
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [origin_search_pkg::FEED_W-1:0] speed_cmd,
	input wire logic dir_cw,
	input wire logic point_to_point_move,
	input wire logic [origin_search_pkg::POS_W-1:0] ptp_target,
	input wire logic abs_data_request,
	input wire logic load,
	input wire logic [31:0] load_pos,
	input wire logic prox_fitted,
	input wire logic prox_nc,
	input wire logic [1:0] idx_mode,
	output logic cw_limit_n,
	output logic ccw_limit_n,
	output logic near_origin,
	output logic index_pulse,
	output logic abs_data_valid,
	output logic [origin_search_pkg::POS_W-1:0] abs_position,
	output logic [origin_search_pkg::POS_W-1:0] encoder_position,
	output logic ptp_done
);
	int pos = 0;
	int tick = 0;
	int ptp_wait = 0;
	logic near_act;

	// ************************************************************
	// switch and encoder pins
	// ************************************************************
	// contacts open at the ends, so a broken wire also reads as a limit
	assign cw_limit_n = !(pos >= CW_END);
	assign ccw_limit_n = !(pos <= CCW_END);
	assign near_act = prox_fitted && pos >= NEAR_LO && pos <= NEAR_HI;
	assign near_origin = prox_nc ? !near_act : near_act;
	// stuck mode holds the index line high to expose level detection
	assign index_pulse = idx_mode[1] | (idx_mode[0] & (pos % 8 == 0));
	// data outside the valid window shows the inverse pattern, never the last value
	assign abs_position = abs_data_valid ? ABS_DATA : ~ABS_DATA;
	assign encoder_position = 32'(pos);

	// ************************************************************
	// motion
	// ************************************************************
	// one step every STEP cycles while speed is commanded; the ends are hard stops
	always @(posedge clk) begin
		ptp_done <= 1'b0;
		abs_data_valid <= abs_data_request & !rst;
		if (rst) begin
			tick <= 0;
			ptp_wait <= 0;
		end else if (load) begin
			pos <= int'(load_pos);
			tick <= 0;
		end else if (point_to_point_move) begin
			ptp_wait <= 6;
		end else if (ptp_wait > 1) begin
			ptp_wait <= ptp_wait - 1;
		end else if (ptp_wait == 1) begin
			pos <= int'(ptp_target);
			ptp_wait <= 0;
			ptp_done <= 1'b1;
		end else if (speed_cmd != '0) begin
			tick <= (tick == STEP - 1) ? 0 : tick + 1;
			if (tick == STEP - 1 && dir_cw && pos < CW_END) begin
				pos <= pos + 1;
			end
			if (tick == STEP - 1 && !dir_cw && pos > CCW_END) begin
				pos <= pos - 1;
			end
		end
	end
endmodule

// [origin_search_sequencer_tb.sv]
// self-checking bench for the origin search sequencer
`timescale 1ns/10ps
module origin_search_sequencer_tb;
	import origin_search_pkg::*;

	// ************************************************************
	// signals
	// ************************************************************
	localparam logic [31:0] HIGH = 32'h0000_0123;
	localparam logic [31:0] LOW = 32'h0000_0045;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [31:0] reg_rdata;
	logic cw_limit_n, ccw_limit_n, near_origin, index_pulse, abs_data_valid, ptp_done;
	logic [POS_W-1:0] abs_position, encoder_position, ptp_target;
	logic [FEED_W-1:0] speed_cmd;
	logic dir_cw, run_cmd, point_to_point_move, abs_data_request, busy, search_error;
	logic load = 1'b0;
	logic [31:0] load_pos = 32'h0000_0000;
	logic prox_fitted = 1'b1;
	logic prox_nc = 1'b0;
	logic [1:0] idx_mode = 2'h1;
	logic [31:0] d;
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;

	// short index watchdog keeps the error runs brief
	origin_search_sequencer #(.Z_TIMEOUT(50)) dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.cw_limit_n(cw_limit_n), .ccw_limit_n(ccw_limit_n), .near_origin(near_origin),
		.index_pulse(index_pulse), .abs_data_valid(abs_data_valid), .abs_position(abs_position),
		.encoder_position(encoder_position), .ptp_done(ptp_done), .speed_cmd(speed_cmd), .dir_cw(dir_cw),
		.run_cmd(run_cmd), .point_to_point_move(point_to_point_move), .ptp_target(ptp_target),
		.abs_data_request(abs_data_request), .busy(busy), .search_error(search_error));

	axis_model axis (.clk(clk), .rst(rst), .speed_cmd(speed_cmd), .dir_cw(dir_cw),
		.point_to_point_move(point_to_point_move), .ptp_target(ptp_target),
		.abs_data_request(abs_data_request), .load(load), .load_pos(load_pos), .prox_fitted(prox_fitted),
		.prox_nc(prox_nc), .idx_mode(idx_mode), .cw_limit_n(cw_limit_n), .ccw_limit_n(ccw_limit_n),
		.near_origin(near_origin), .index_pulse(index_pulse), .abs_data_valid(abs_data_valid),
		.abs_position(abs_position), .encoder_position(encoder_position), .ptp_done(ptp_done));

	// ************************************************************
	// clock, watchdog and tasks
	// ************************************************************
	// 40 MHz clock
	always #12.5 clk = ~clk;

	// a hung wait counts as a failure
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			end_sim();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 v = reg_rdata;
	endtask

	// one search from position zero, watched cycle by cycle until busy drops
	task automatic search(input logic [6:0] cfg, input logic fit, input logic [1:0] idx, input logic err,
			input logic [31:0] origin, input int revs);
		logic prev_dir;
		logic seen_low;
		logic [31:0] v;
		int n_rev;
		int n;
		seen_low = 1'b0;
		n_rev = 0;
		load_pos <= 32'h0;
		load <= 1'b1;
		prox_fitted <= fit;
		prox_nc <= cfg[CFG_PROX_NC_BIT];
		idx_mode <= idx;
		@(posedge clk);
		load <= 1'b0;
		repeat (3) @(posedge clk);
		wr(REG_CONFIG, 32'(cfg));
		wr(REG_CONTROL, 32'h1);
		#1 check("busy on start", 32'(busy), 32'h1);
		@(posedge clk);
		#1 check("start speed", 32'(speed_cmd), HIGH);
		check("start dir", 32'(dir_cw), 32'(cfg[CFG_DIR_BIT]));
		prev_dir = dir_cw;
		for (n = 0; n < 3000 && busy === 1'b1; n++) begin
			@(posedge clk);
			#1;
			seen_low |= (speed_cmd === LOW[15:0]);
			if (point_to_point_move === 1'b1) begin
				check("origin stop", 32'(speed_cmd), 32'h0);
				check("offset target", ptp_target, origin);
			end
			if (dir_cw !== prev_dir) begin
				check("reverse stop", 32'(speed_cmd), 32'h0);
				n_rev++;
			end
			prev_dir = dir_cw;
		end
		check("busy end", 32'(busy), 32'h0);
		check("error flag", 32'(search_error), 32'(err));
		check("reversals", 32'(n_rev), 32'(revs));
		if (!err) begin
			check("low feed", 32'(seen_low), 32'h1);
			rd(REG_ORIGIN, v);
			check("origin", v, origin);
		end
	endtask

	task end_sim();
		if (num_errors == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	// origin expectations: index at 32 after the zone, 56 when the limit stands in, plus offset 5
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(REG_CONFIG, d);
		check("config reset", d, 32'(CFG_RESET));
		rd(REG_STATUS, d);
		check("status reset", d, 32'h0000_0004);
		rd(4'h9, d);
		check("unmapped read", d, 32'h0);
		wr(REG_HIGH_FEED, HIGH);
		wr(REG_LOW_FEED, LOW);
		wr(REG_OFFSET, 32'h5);
		rd(REG_HIGH_FEED, d);
		check("high feed", d, HIGH);
		search(7'h05, 1'b1, 2'h1, 1'b0, 32'd37, 0);
		search(7'h15, 1'b1, 2'h1, 1'b0, 32'd37, 0);
		search(7'h01, 1'b1, 2'h1, 1'b0, 32'd37, 1);
		search(7'h02, 1'b1, 2'h1, 1'b1, 32'h0, 0);
		search(7'h05, 1'b1, 2'h2, 1'b1, 32'h0, 0);
		search(7'h25, 1'b0, 2'h1, 1'b0, 32'd61, 1);
		wr(REG_CONFIG, 32'h4);
		wr(REG_CONTROL, 32'h1);
		repeat (2) @(posedge clk);
		#1 check("power-on start", 32'({busy, speed_cmd}), 32'h0);
		load_pos <= 32'd50;
		load <= 1'b1;
		@(posedge clk);
		load <= 1'b0;
		wr(REG_CONFIG, 32'h45);
		wr(REG_CONTROL, 32'h2);
		#1 check("run on", 32'(run_cmd), 32'h1);
		check("request waits", 32'(abs_data_request), 32'h0);
		@(posedge clk);
		#1 check("request rises", 32'(abs_data_request), 32'h1);
		repeat (4) @(posedge clk);
		rd(REG_ORIGIN, d);
		check("abs origin", d, 32'd34);
		wr(REG_CONTROL, 32'h3);
		repeat (2) @(posedge clk);
		#1 check("abs start", 32'(busy), 32'h0);
		end_sim();
	end
endmodule
